// file: verilog/jmbp_port.sv
// jmbp_port: tap, instruction decode, scan registers and memory self-test sequencer
// assumes: tck, tms, tdi come from the board tester; mem_rdata answers one cycle after read
// How it works
// - extest captures pins, chain in path
// - bypass code uses single pass bit
// - idcode preloads identity, shifts it
// - float code: bypass path, outputs tristated
// - clamp drives cell values, bypass path
// - sample captures pins, no disturbance
// - run code starts selftest, debug path
// - result code shifts pass/fail and count
// - mode control code shifts 2-bit mode
// - port 1 writes zeros first
// - up pass: read0 write1 read1
// - up pass: read1 write0 read0
// - down passes, then read zeros
// - march sequence states in order
// - checkerboard write then read
// - inverse checkerboard write then read
// - unique address passes with port 2
// - repeat with ports 3 and 4
// - mode 00 pass/fail, 01 debug
// - chain cells even, from cell 2
// - mode control resets to 00
// - debug packet holds state in 9:4
`timescale 1ns/1ps
`default_nettype none
module jmbp_port #(
   parameter int DEPTH_W = jmbp_pkg::ADDR_W,
   parameter logic [31:0] ID_VALUE = 32'h5A5A_0A5B   // arbitrary identity value
) (
   input  wire logic                          mclk,
   input  wire logic                          resetn,
   input  wire logic                          tck,
   input  wire logic                          tms,
   input  wire logic                          tdi,
   output logic                               tdo,
   output logic                               tdo_oe,
   input  wire logic [jmbp_pkg::RING_W/2-1:0] pin_ring_in,
   output logic [jmbp_pkg::RING_W/2-1:0]      pin_ring_out,
   output logic                               pin_ring_sel,
   output logic                               outputs_float,
   output jmbp_pkg::jmbp_mem_req_t            mem_req,
   input  wire logic [jmbp_pkg::DATA_W-1:0]   mem_rdata
);
   localparam int NCELL = jmbp_pkg::RING_W / 2;
   localparam int CHK_ROW = DEPTH_W / 2;

   jmbp_pkg::jmbp_link_t link;
   logic       tck_d;
   logic       tck_rise;
   logic       tck_fall;
   jmbp_pkg::jmbp_tap_t tap;
   jmbp_pkg::jmbp_tap_t next_tap;
   logic [jmbp_pkg::IR_W-1:0]  ir_sh;
   logic [jmbp_pkg::IR_W-1:0]  ir;
   logic                       pass_bit;
   logic [jmbp_pkg::ID_W-1:0]  id_sh;
   logic [jmbp_pkg::MODE_W-1:0] mode_sh;
   logic [jmbp_pkg::MODE_W-1:0] selftest_mode_control;
   logic [jmbp_pkg::RES_W-1:0]  res_sh;
   logic [jmbp_pkg::DBG_W-1:0]  dbg_sh;
   logic [NCELL-1:0]           ring_sh;
   logic [NCELL-1:0]           ring_upd;
   logic                       serial_bit;
   logic                       start_req;
   jmbp_pkg::jmbp_seq_t        seq;
   logic [1:0]                 wport;
   logic [DEPTH_W-1:0]         addr;
   logic [1:0]                 phase;
   logic                       fail;
   logic [jmbp_pkg::RES_W-2:0] fail_cnt;
   logic                       rd_pend;
   logic [jmbp_pkg::DATA_W-1:0] expect_q;
   logic [jmbp_pkg::DATA_W-1:0] dbg_cmp;
   logic [DEPTH_W-1:0]         dbg_addr;
   jmbp_pkg::jmbp_seq_t        dbg_state;
   logic                       dbg_valid;
   logic                       is_ring;
   logic [DEPTH_W-1:0]         addr_dir;
   logic [jmbp_pkg::DATA_W-1:0] addr_data;
   logic [DEPTH_W-1:0]         addr_q;

   jmbp_sync #(.W(3)) u_sync (
      .mclk     (mclk),
      .resetn   (resetn),
      .async_in ({tck, tms, tdi}),
      .sync_out (link)
   );

   always_ff @(posedge mclk)
   begin
      if (!resetn)
         tck_d <= 1'b0;
      else
         tck_d <= link.tck;
   end
   assign tck_rise = link.tck & ~tck_d;
   assign tck_fall = ~link.tck & tck_d;

   // tap state machine
   always_comb
   begin
      case (tap)
         jmbp_pkg::T_RESET: next_tap = link.tms ? jmbp_pkg::T_RESET : jmbp_pkg::T_IDLE;
         jmbp_pkg::T_IDLE:  next_tap = link.tms ? jmbp_pkg::T_SELDR : jmbp_pkg::T_IDLE;
         jmbp_pkg::T_SELDR: next_tap = link.tms ? jmbp_pkg::T_SELIR : jmbp_pkg::T_CAPDR;
         jmbp_pkg::T_CAPDR: next_tap = link.tms ? jmbp_pkg::T_EX1DR : jmbp_pkg::T_SHDR;
         jmbp_pkg::T_SHDR:  next_tap = link.tms ? jmbp_pkg::T_EX1DR : jmbp_pkg::T_SHDR;
         jmbp_pkg::T_EX1DR: next_tap = link.tms ? jmbp_pkg::T_UPDR : jmbp_pkg::T_PSDR;
         jmbp_pkg::T_PSDR:  next_tap = link.tms ? jmbp_pkg::T_EX2DR : jmbp_pkg::T_PSDR;
         jmbp_pkg::T_EX2DR: next_tap = link.tms ? jmbp_pkg::T_UPDR : jmbp_pkg::T_SHDR;
         jmbp_pkg::T_UPDR:  next_tap = link.tms ? jmbp_pkg::T_SELDR : jmbp_pkg::T_IDLE;
         jmbp_pkg::T_SELIR: next_tap = link.tms ? jmbp_pkg::T_RESET : jmbp_pkg::T_CAPIR;
         jmbp_pkg::T_CAPIR: next_tap = link.tms ? jmbp_pkg::T_EX1IR : jmbp_pkg::T_SHIR;
         jmbp_pkg::T_SHIR:  next_tap = link.tms ? jmbp_pkg::T_EX1IR : jmbp_pkg::T_SHIR;
         jmbp_pkg::T_EX1IR: next_tap = link.tms ? jmbp_pkg::T_UPIR : jmbp_pkg::T_PSIR;
         jmbp_pkg::T_PSIR:  next_tap = link.tms ? jmbp_pkg::T_EX2IR : jmbp_pkg::T_PSIR;
         jmbp_pkg::T_EX2IR: next_tap = link.tms ? jmbp_pkg::T_UPIR : jmbp_pkg::T_SHIR;
         jmbp_pkg::T_UPIR:  next_tap = link.tms ? jmbp_pkg::T_SELDR : jmbp_pkg::T_IDLE;
         default:           next_tap = jmbp_pkg::T_RESET;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
         tap <= jmbp_pkg::T_RESET;
      else if (tck_rise)
         tap <= next_tap;
   end

   // instruction register, reset loads bypass
   always_ff @(posedge mclk)
   begin
      if (!resetn || tap == jmbp_pkg::T_RESET)
      begin
         ir_sh <= jmbp_pkg::I_BYPASS;
         ir    <= jmbp_pkg::I_BYPASS;
      end
      else if (tck_rise)
      begin
         if (tap == jmbp_pkg::T_CAPIR)
            ir_sh <= jmbp_pkg::IR_CAPTURE;
         else if (tap == jmbp_pkg::T_SHIR)
            ir_sh <= {link.tdi, ir_sh[jmbp_pkg::IR_W-1:1]};
         else if (tap == jmbp_pkg::T_UPIR)
            ir <= ir_sh;
      end
   end

   assign is_ring = (ir == jmbp_pkg::I_EXTEST) || (ir == jmbp_pkg::I_SAMPLE);

   // data registers: capture and shift
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         pass_bit <= 1'b0;
         id_sh    <= '0;
         mode_sh  <= '0;
         res_sh   <= '0;
         ring_sh  <= '0;
      end
      else if (tck_rise && tap == jmbp_pkg::T_CAPDR)
      begin
         pass_bit <= 1'b0;
         id_sh    <= ID_VALUE;
         mode_sh  <= selftest_mode_control;
         res_sh   <= {fail_cnt, fail};
         if (is_ring)
            ring_sh <= pin_ring_in;
      end
      else if (tck_rise && tap == jmbp_pkg::T_SHDR)
      begin
         case (ir)
            jmbp_pkg::I_EXTEST, jmbp_pkg::I_SAMPLE:
               ring_sh <= {link.tdi, ring_sh[NCELL-1:1]};
            jmbp_pkg::I_IDCODE:
               id_sh <= {link.tdi, id_sh[jmbp_pkg::ID_W-1:1]};
            jmbp_pkg::I_MODECTL:
               mode_sh <= {link.tdi, mode_sh[1]};
            jmbp_pkg::I_RESULT:
               res_sh <= {link.tdi, res_sh[jmbp_pkg::RES_W-1:1]};
            default:
               pass_bit <= link.tdi;
         endcase
      end
   end

   // update stage for ring and mode control
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         ring_upd              <= '0;
         selftest_mode_control <= jmbp_pkg::MODE_RESET;
      end
      else if (tck_rise && tap == jmbp_pkg::T_UPDR)
      begin
         if (is_ring)
            ring_upd <= ring_sh;
         if (ir == jmbp_pkg::I_MODECTL)
            selftest_mode_control <= mode_sh;
      end
   end

   // pin control outputs
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         pin_ring_out  <= '0;
         pin_ring_sel  <= 1'b0;
         outputs_float <= 1'b0;
      end
      else
      begin
         pin_ring_out  <= ring_upd;
         pin_ring_sel  <= (ir == jmbp_pkg::I_EXTEST) || (ir == jmbp_pkg::I_CLAMP);
         outputs_float <= (ir == jmbp_pkg::I_FLOAT);
      end
   end

   // serial path selection
   always_comb
   begin
      case (ir)
         jmbp_pkg::I_EXTEST, jmbp_pkg::I_SAMPLE: serial_bit = ring_sh[0];
         jmbp_pkg::I_IDCODE:  serial_bit = id_sh[0];
         jmbp_pkg::I_MODECTL: serial_bit = mode_sh[0];
         jmbp_pkg::I_RESULT:  serial_bit = res_sh[0];
         jmbp_pkg::I_RUN:     serial_bit = dbg_sh[0];
         jmbp_pkg::I_CLAMP, jmbp_pkg::I_FLOAT, jmbp_pkg::I_BYPASS:
            serial_bit = pass_bit;
         default:             serial_bit = pass_bit;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo    <= (tap == jmbp_pkg::T_SHIR) ? ir_sh[0] : serial_bit;
         tdo_oe <= (tap == jmbp_pkg::T_SHIR) || (tap == jmbp_pkg::T_SHDR);
      end
   end

   // debug packet register
   always_ff @(posedge mclk)
   begin
      if (!resetn)
         dbg_sh <= '0;
      else if (tck_rise && ir == jmbp_pkg::I_RUN && tap == jmbp_pkg::T_CAPDR)
      begin
         dbg_sh <= '0;
         dbg_sh[jmbp_pkg::DBG_HDR_HI:jmbp_pkg::DBG_HDR_LO] <= 2'h3;
         dbg_sh[jmbp_pkg::DBG_TRL_HI:0] <= 2'h3;
         dbg_sh[jmbp_pkg::DBG_DONE] <= (seq == jmbp_pkg::S_DONE);
         dbg_sh[jmbp_pkg::DBG_ADR_LO +: DEPTH_W] <= dbg_addr;
         dbg_sh[jmbp_pkg::DBG_ST_LO +: $bits(jmbp_pkg::jmbp_seq_t)] <= dbg_state;
         dbg_sh[jmbp_pkg::DBG_CMP_LO +: jmbp_pkg::DATA_W] <= dbg_cmp;
      end
      else if (tck_rise && ir == jmbp_pkg::I_RUN && tap == jmbp_pkg::T_SHDR)
         dbg_sh <= {link.tdi, dbg_sh[jmbp_pkg::DBG_W-1:1]};
   end

   // only an idle sequencer starts, so results survive extra idle clocks
   assign start_req = tck_rise && ir == jmbp_pkg::I_RUN && tap == jmbp_pkg::T_IDLE &&
                      seq == jmbp_pkg::S_IDLE;

   // sequencer: each state walks the array, move and march up/down states in read/write/read phases
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         seq   <= jmbp_pkg::S_IDLE;
         wport <= 2'h0;
         addr  <= '0;
         phase <= 2'h0;
      end
      else if (seq == jmbp_pkg::S_IDLE)
      begin
         if (start_req)
         begin
            seq   <= jmbp_pkg::S_MOV_Z;
            wport <= 2'h0;
            addr  <= '0;
            phase <= 2'h0;
         end
      end
      else if (seq != jmbp_pkg::S_DONE)
      begin
         if (phase != 2'h2 && (seq == jmbp_pkg::S_MOV_1U || seq == jmbp_pkg::S_MOV_0U ||
             seq == jmbp_pkg::S_MOV_1D || seq == jmbp_pkg::S_MOV_0D ||
             seq == jmbp_pkg::S_MAR_1U || seq == jmbp_pkg::S_MAR_0U ||
             seq == jmbp_pkg::S_MAR_1D || seq == jmbp_pkg::S_MAR_0D))
            phase <= phase + 2'h1;
         else
         begin
            phase <= 2'h0;
            if (addr != '1)
               addr <= addr + 1'b1;
            else
            begin
               addr <= '0;
               case (seq)
                  jmbp_pkg::S_MOV_Z:  seq <= jmbp_pkg::S_MOV_1U;
                  jmbp_pkg::S_MOV_1U: seq <= jmbp_pkg::S_MOV_0U;
                  jmbp_pkg::S_MOV_0U: seq <= jmbp_pkg::S_MOV_1D;
                  jmbp_pkg::S_MOV_1D: seq <= jmbp_pkg::S_MOV_0D;
                  jmbp_pkg::S_MOV_0D: seq <= jmbp_pkg::S_MOV_RD;
                  jmbp_pkg::S_MOV_RD: seq <= jmbp_pkg::S_MAR_Z;
                  jmbp_pkg::S_MAR_Z:  seq <= jmbp_pkg::S_MAR_1U;
                  jmbp_pkg::S_MAR_1U: seq <= jmbp_pkg::S_MAR_0U;
                  jmbp_pkg::S_MAR_0U: seq <= jmbp_pkg::S_MAR_1D;
                  jmbp_pkg::S_MAR_1D: seq <= jmbp_pkg::S_MAR_0D;
                  jmbp_pkg::S_MAR_0D: seq <= jmbp_pkg::S_MAR_RD;
                  jmbp_pkg::S_MAR_RD: seq <= jmbp_pkg::S_CHK_W;
                  jmbp_pkg::S_CHK_W:  seq <= jmbp_pkg::S_CHK_R;
                  jmbp_pkg::S_CHK_R:  seq <= jmbp_pkg::S_NCHK_W;
                  jmbp_pkg::S_NCHK_W: seq <= jmbp_pkg::S_NCHK_R;
                  jmbp_pkg::S_NCHK_R:
                  begin
                     seq   <= jmbp_pkg::S_UA_Z;
                     wport <= 2'h1;
                  end
                  jmbp_pkg::S_UA_Z:   seq <= jmbp_pkg::S_UA_W;
                  jmbp_pkg::S_UA_W:   seq <= jmbp_pkg::S_UA_R;
                  jmbp_pkg::S_UA_R:   seq <= jmbp_pkg::S_UA_O;
                  jmbp_pkg::S_UA_O:   seq <= jmbp_pkg::S_UA_NW;
                  jmbp_pkg::S_UA_NW:  seq <= jmbp_pkg::S_UA_NR;
                  jmbp_pkg::S_UA_NR:
                  begin
                     if (wport == 2'h3)
                        seq <= jmbp_pkg::S_DONE;
                     else
                     begin
                        seq   <= jmbp_pkg::S_UA_Z;
                        wport <= wport + 2'h1;
                     end
                  end
                  default:            seq <= jmbp_pkg::S_DONE;
               endcase
            end
         end
      end
   end

   // down passes walk the inverted address
   assign addr_dir  = (seq == jmbp_pkg::S_MOV_1D || seq == jmbp_pkg::S_MOV_0D ||
                       seq == jmbp_pkg::S_MAR_1D || seq == jmbp_pkg::S_MAR_0D) ? ~addr : addr;
   assign addr_data = (jmbp_pkg::DATA_W)'(addr);

   // memory request generation
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         mem_req  <= '0;
         expect_q <= '0;
         addr_q   <= '0;
         rd_pend  <= 1'b0;
      end
      else
      begin
         mem_req.en   <= (seq != jmbp_pkg::S_IDLE) && (seq != jmbp_pkg::S_DONE);
         mem_req.port <= wport;
         mem_req.addr <= (jmbp_pkg::ADDR_W)'(addr_dir);
         case (seq)
            jmbp_pkg::S_MOV_Z, jmbp_pkg::S_MAR_Z, jmbp_pkg::S_UA_Z:
            begin
               mem_req.wr   <= 1'b1;
               mem_req.data <= '0;
            end
            jmbp_pkg::S_UA_O:
            begin
               mem_req.wr   <= 1'b1;
               mem_req.data <= '1;
            end
            jmbp_pkg::S_CHK_W, jmbp_pkg::S_NCHK_W:
            begin
               mem_req.wr   <= 1'b1;
               mem_req.data <= {jmbp_pkg::DATA_W{addr[0] ^ addr[CHK_ROW] ^
                                (seq == jmbp_pkg::S_NCHK_W)}};
            end
            jmbp_pkg::S_UA_W, jmbp_pkg::S_UA_NW:
            begin
               mem_req.wr   <= 1'b1;
               mem_req.data <= addr_data ^ {jmbp_pkg::DATA_W{seq == jmbp_pkg::S_UA_NW}};
            end
            jmbp_pkg::S_MOV_1U, jmbp_pkg::S_MOV_1D, jmbp_pkg::S_MAR_1U, jmbp_pkg::S_MAR_1D,
            jmbp_pkg::S_MOV_0U, jmbp_pkg::S_MOV_0D, jmbp_pkg::S_MAR_0U, jmbp_pkg::S_MAR_0D:
            begin
               mem_req.wr   <= (phase == 2'h1);
               mem_req.data <= {jmbp_pkg::DATA_W{(phase == 2'h0) ^
                                (seq == jmbp_pkg::S_MOV_1U || seq == jmbp_pkg::S_MOV_1D ||
                                 seq == jmbp_pkg::S_MAR_1U || seq == jmbp_pkg::S_MAR_1D)}};
            end
            default:
            begin
               mem_req.wr   <= 1'b0;
               mem_req.data <= (seq == jmbp_pkg::S_CHK_R || seq == jmbp_pkg::S_NCHK_R) ?
                  {jmbp_pkg::DATA_W{addr[0] ^ addr[CHK_ROW] ^ (seq == jmbp_pkg::S_NCHK_R)}} :
                  (seq == jmbp_pkg::S_UA_R) ? addr_data :
                  (seq == jmbp_pkg::S_UA_NR) ? ~addr_data : '0;
            end
         endcase
         rd_pend  <= mem_req.en && !mem_req.wr;
         expect_q <= mem_req.data;
         addr_q   <= mem_req.addr[DEPTH_W-1:0];
      end
   end

   // compare and record failures
   always_ff @(posedge mclk)
   begin
      if (!resetn || start_req)
      begin
         fail      <= 1'b0;
         fail_cnt  <= '0;
         dbg_cmp   <= '0;
         dbg_addr  <= '0;
         dbg_state <= jmbp_pkg::S_IDLE;
         dbg_valid <= 1'b0;
      end
      else if (rd_pend && mem_rdata != expect_q)
      begin
         fail     <= 1'b1;
         fail_cnt <= fail_cnt + 1'b1;
         if (selftest_mode_control == jmbp_pkg::MODE_DEBUG && !dbg_valid)
         begin
            dbg_valid <= 1'b1;
            dbg_cmp   <= mem_rdata ^ expect_q;
            dbg_addr  <= addr_q;
            dbg_state <= seq;
         end
      end
   end
endmodule : jmbp_port
`default_nettype wire

// file: pkg/jmbp_pkg.sv
// jmbp_pkg: constants and types for the test access and memory self-test port
// assumes: the port is clocked by mclk at 50 MHz, with tck sampled as a pin
package jmbp_pkg;
   localparam int IR_W       = 4;
   localparam int ID_W       = 32;
   localparam int MODE_W     = 2;
   localparam int RES_W      = 25;
   localparam int DBG_W      = 100;
   localparam int RING_W     = 392;
   localparam int ADDR_W     = 16;
   localparam int DATA_W     = 18;
   localparam int NPORT      = 4;
   localparam int BSR_BIT0   = 2;

   // instruction codes
   localparam logic [3:0] I_EXTEST  = 4'h0;
   localparam logic [3:0] I_SAMPLE  = 4'h1;
   localparam logic [3:0] I_RESULT  = 4'h2;
   localparam logic [3:0] I_MODECTL = 4'h3;
   localparam logic [3:0] I_CLAMP   = 4'h5;
   localparam logic [3:0] I_FLOAT   = 4'h6;
   localparam logic [3:0] I_IDCODE  = 4'h7;
   localparam logic [3:0] I_RUN     = 4'h8;
   localparam logic [3:0] I_BYPASS  = 4'hF;
   localparam logic [3:0] IR_CAPTURE = 4'h1;

   localparam logic [1:0] MODE_PASSFAIL = 2'h0;
   localparam logic [1:0] MODE_DEBUG    = 2'h1;
   localparam logic [1:0] MODE_RESET    = 2'h0;

   // debug packet field positions
   localparam int DBG_HDR_HI  = 99;
   localparam int DBG_HDR_LO  = 98;
   localparam int DBG_CMP_LO  = 26;
   localparam int DBG_ADR_LO  = 10;
   localparam int DBG_ST_LO   = 4;
   localparam int DBG_DONE    = 2;
   localparam int DBG_TRL_HI  = 1;

   // tap states, binary coded
   typedef enum logic [3:0] {
      T_RESET = 4'h0, T_IDLE = 4'h1, T_SELDR = 4'h2, T_CAPDR = 4'h3,
      T_SHDR  = 4'h4, T_EX1DR = 4'h5, T_PSDR = 4'h6, T_EX2DR = 4'h7,
      T_UPDR  = 4'h8, T_SELIR = 4'h9, T_CAPIR = 4'hA, T_SHIR = 4'hB,
      T_EX1IR = 4'hC, T_PSIR = 4'hD, T_EX2IR = 4'hE, T_UPIR = 4'hF
   } jmbp_tap_t;

   // self-test sequencer states, 6-bit codes
   typedef enum logic [5:0] {
      S_IDLE    = 6'h00,
      S_MOV_Z   = 6'h01, S_MOV_1U = 6'h03, S_MOV_0U = 6'h02,
      S_MOV_1D  = 6'h06, S_MOV_0D = 6'h07, S_MOV_RD = 6'h05,
      S_MAR_Z   = 6'h04, S_MAR_1U = 6'h0C, S_MAR_0U = 6'h0D,
      S_MAR_1D  = 6'h0F, S_MAR_0D = 6'h0E, S_MAR_RD = 6'h0A,
      S_CHK_W   = 6'h0B, S_CHK_R  = 6'h09, S_NCHK_W = 6'h08,
      S_NCHK_R  = 6'h18,
      S_UA_Z    = 6'h19, S_UA_W   = 6'h1B, S_UA_R   = 6'h1A,
      S_UA_O    = 6'h1E, S_UA_NW  = 6'h1F, S_UA_NR  = 6'h1D,
      S_DONE    = 6'h32
   } jmbp_seq_t;

   // memory access from sequencer
   typedef struct packed {
      logic              en;
      logic              wr;
      logic [1:0]        port;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } jmbp_mem_req_t;

   // serial link pins after sampling
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } jmbp_link_t;
endpackage : jmbp_pkg

// file: verilog/jmbp_sync.sv
// jmbp_sync: two-flop synchroniser for a bundle of pin levels
// assumes: inputs are asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module jmbp_sync #(
   parameter int W = 3
) (
   input  wire logic         mclk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] stage1;

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         stage1   <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : jmbp_sync
`default_nettype wire

// file: bench/jmbp_port_checker.sv
// jmbp_port_checker: pin timing relations of the test port
// assumes: bound to jmbp_port; tck is a pin sampled on mclk
`timescale 1ns/1ps
`default_nettype none
module jmbp_port_checker (
   input  wire logic                    mclk,
   input  wire logic                    resetn,
   input  wire logic                    tck,
   input  wire logic                    tdo,
   input  wire logic                    tdo_oe,
   input  wire logic                    pin_ring_sel,
   input  wire logic                    outputs_float,
   input  wire jmbp_pkg::jmbp_mem_req_t mem_req
);
   logic       tck_q;
   logic [3:0] since_tck;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   always_ff @(posedge mclk)
   begin
      tck_q <= tck;
   end
   // cycles since the tck pin last moved
   always_ff @(posedge mclk)
   begin
      if (!resetn)
         since_tck <= 4'hF;
      else if (tck != tck_q)
         since_tck <= 4'h0;
      else if (since_tck != 4'hF)
         since_tck <= since_tck + 4'h1;
   end
   property p_tdo_on_tck;
      !$stable(tdo) |-> since_tck <= 4'h7;
   endproperty
   a_tdo_on_tck: assert property (p_tdo_on_tck) else $error("tdo moved off tck");
   property p_oe_on_tck;
      !$stable(tdo_oe) |-> since_tck <= 4'h7;
   endproperty
   a_oe_on_tck: assert property (p_oe_on_tck) else $error("tdo_oe moved off tck");
   property p_float_on_tck;
      !$stable(outputs_float) |-> since_tck <= 4'h7;
   endproperty
   a_float_on_tck: assert property (p_float_on_tck) else $error("float moved off tck");
   property p_sel_on_tck;
      !$stable(pin_ring_sel) |-> since_tck <= 4'h7;
   endproperty
   a_sel_on_tck: assert property (p_sel_on_tck) else $error("sel moved off tck");
   property p_float_excl;
      outputs_float |-> !pin_ring_sel;
   endproperty
   a_float_excl: assert property (p_float_excl) else $error("float with cells");
   property p_start_on_tck;
      $rose(mem_req.en) |-> since_tck <= 4'h7;
   endproperty
   a_start_on_tck: assert property (p_start_on_tck) else $error("start off tck");
   property p_zero_first;
      $rose(mem_req.en) |-> mem_req.wr && mem_req.port == 2'h0 && mem_req.addr == 16'h0
         && mem_req.data == 18'h0;
   endproperty
   a_zero_first: assert property (p_zero_first) else $error("bad first access");
   property p_zero_sweep;
      $rose(mem_req.en) |=> (mem_req.en && mem_req.wr && mem_req.data == 18'h0
         && mem_req.addr == $past(mem_req.addr) + 16'h1)[*8];
   endproperty
   a_zero_sweep: assert property (p_zero_sweep) else $error("bad zero sweep");
   c_run: cover property ($rose(mem_req.en));
   c_float: cover property ($rose(outputs_float));
   c_sel: cover property ($rose(pin_ring_sel));
endmodule : jmbp_port_checker
bind jmbp_port jmbp_port_checker chk (.mclk(mclk), .resetn(resetn), .tck(tck), .tdo(tdo),
   .tdo_oe(tdo_oe), .pin_ring_sel(pin_ring_sel), .outputs_float(outputs_float),
   .mem_req(mem_req));
`default_nettype wire

// file: bench/jmbp_tester.sv
// jmbp_tester: board test controller driving the serial pins
// assumes: tasks entered at a falling mclk edge; tck stands low between frames
`timescale 1ns/1ps
`default_nettype none
module jmbp_tester (
   input  wire logic mclk,
   input  wire logic tdo,
   output logic      tck,
   output logic      tms,
   output logic      tdi
);
   logic b;
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // one 160 ns tck period, tdo taken at the rise
   task automatic step(input logic m, input logic d);
      tms = m;
      tdi = d;
      repeat (5) @(negedge mclk);
      b = tdo;
      tck = 1'b1;
      repeat (3) @(negedge mclk);
      tck = 1'b0;
   endtask : step
   task automatic tap_reset();
      repeat (5) step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask : tap_reset
   // ir or dr scan from idle back to idle, lsb first
   task automatic scan(input logic ir, input int n, input logic [255:0] d,
                       output logic [255:0] q);
      q = '0;
      step(1'b1, 1'b0);
      if (ir)
         step(1'b1, 1'b0);
      repeat (2) step(1'b0, 1'b0);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, d[i]);
         q[i] = b;
      end
      step(1'b1, ~d[n - 1]);
      step(1'b0, ~d[n - 1]);
   endtask : scan
endmodule : jmbp_tester
`default_nettype wire

// file: bench/test_jmbp_port.sv
// test_jmbp_port: self-checking bench of the test port and self-test
// assumes: jmbp_pkg, tester and checker compiled before this file
`timescale 1ns/1ps
`default_nettype none
module test_jmbp_port;
   localparam logic [31:0] ID = 32'h0000A5A3;  // arbitrary identity value
   logic                    mclk, resetn, tck, tms, tdi, tdo, sel, flt, corrupt;
   logic [195:0]            ring_in, ring_out, ring_d;
   logic [17:0]             mem_rdata;
   logic [3:0]              raddr;
   logic [17:0]             mem [16];
   logic [255:0]            q, d;
   logic [3:0]              codes [10] = '{4'hF, 4'h4, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD,
                                           4'hE, 4'h6, 4'h5};
   jmbp_pkg::jmbp_mem_req_t mem_req;
   int                      miscompares, compares, nreads;
   jmbp_port #(.DEPTH_W(4), .ID_VALUE(ID)) uut (.mclk(mclk), .resetn(resetn), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(), .pin_ring_in(ring_in),
      .pin_ring_out(ring_out), .pin_ring_sel(sel), .outputs_float(flt),
      .mem_req(mem_req), .mem_rdata(mem_rdata));
   jmbp_tester t (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
   // memory: read data stands at the second mclk rise after the request
   always @(negedge mclk)
   begin
      if (mem_req.en && mem_req.wr)
         mem[mem_req.addr[3:0]] <= mem_req.data;
      if (mem_req.en && !mem_req.wr)
         nreads++;
      mem_rdata <= mem[raddr] ^ {17'h0, corrupt};
      raddr <= mem_req.addr[3:0];
   end
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic ld(input logic [3:0] c);
      t.scan(1'b1, 4, 256'(c), q);
   endtask : ld
   task automatic tally_and_finish();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      #1500000;
      miscompares++;
      tally_and_finish();
   end
   initial
   begin
      resetn = 1'b0;
      corrupt = 1'b0;
      mem_rdata = '0;
      void'($urandom(32'h509143F8));
      for (int i = 0; i < 196; i++)
      begin
         ring_in[i] = 1'($urandom());
         ring_d[i] = 1'($urandom());
      end
      repeat (10) @(negedge mclk);
      resetn = 1'b1;
      repeat (3) @(negedge mclk);
      t.tap_reset();
      ld(4'h7);
      t.scan(1'b0, 32, '0, q);
      chk(q, 256'(ID));
      for (int c = 0; c < 2; c++)
      begin
         ld(4'(c));
         t.scan(1'b0, 196, 256'(ring_d), q);
         chk(q, 256'(ring_in));
         chk(256'(sel), 256'(c == 0));
      end
      foreach (codes[k])
      begin
         ld(codes[k]);
         d = 256'($urandom());
         t.scan(1'b0, 8, d, q);
         chk(q, {d[254:0], 1'b0} & 256'hFF);
         chk(256'(flt), 256'(codes[k] == 4'h6));
         chk(256'(sel), 256'(codes[k] == 4'h5));
      end
      chk(256'(ring_out), 256'(ring_d));
      ld(4'h3);
      t.scan(1'b0, 2, 256'h1, q);
      chk(q, 256'h0);
      t.scan(1'b0, 2, 256'h0, q);
      chk(q, 256'h1);
      for (int r = 0; r < 2; r++)
      begin
         ld(4'h8);
         nreads = 0;
         repeat (450) t.step(1'b0, 1'b0);
         t.scan(1'b0, 100, '0, q);
         chk(q, 256'({2'h3, 72'(r), 16'h0, 6'(r * 3), 4'h7}));
         ld(4'h2);
         t.scan(1'b0, 25, '0, q);
         chk(q, r ? 256'({nreads[23:0], 1'b1}) : 256'h0);
         corrupt = 1'b1;
         resetn = 1'b0;
         repeat (2) @(negedge mclk);
         resetn = 1'b1;
         repeat (3) @(negedge mclk);
         t.tap_reset();
         ld(4'h3);
         t.scan(1'b0, 2, 256'h1, q);
         chk(q, 256'h0);
      end
      tally_and_finish();
   end
endmodule : test_jmbp_port
`default_nettype wire
